// File: rtl/tdaf_consts.svh
// Configuration numbers, field positions and reset values of the filter.
`ifndef TDAF_CONSTS_SVH
`define TDAF_CONSTS_SVH

// ==========================================================================
// Configuration variable numbers
`define TDAF_CV_SHORT      10'h001
`define TDAF_CV_LONG_HI    10'h011
`define TDAF_CV_LONG_LO    10'h012
`define TDAF_CV_CONFIG     10'h01d
`define TDAF_CV_PROTO      10'h02f
`define TDAF_CV_EXT        10'h031

// ==========================================================================
// Field positions
`define TDAF_LONG_SEL_BIT  5
`define TDAF_CONSEC_HI_BIT 7
`define TDAF_CONSEC_LO_BIT 3
`define TDAF_EN_DCC_BIT    0
`define TDAF_EN_AUTO_BIT   1
`define TDAF_EN_LEG_BIT    2
`define TDAF_EN_FOURTH_BIT 3
`define TDAF_LONG_HI_BITS  6

// ==========================================================================
// Reset values
`define TDAF_SHORT_RST     8'h03
`define TDAF_LONG_HI_RST   8'hc0
`define TDAF_LONG_LO_RST   8'h00
`define TDAF_CONFIG_RST    8'h00
`define TDAF_PROTO_RST     8'h0f
`define TDAF_EXT_RST       8'h13
`define TDAF_DCC_ONLY_MASK 8'h01

`endif

// File: rtl/tdaf_pkg.sv
// Types shared by the track decoder address filter.
package tdaf_pkg;

  typedef enum logic [2:0] {
    TDAF_P_DCC    = 3'h0,
    TDAF_P_AUTO   = 3'h1,
    TDAF_P_LEGACY = 3'h2,
    TDAF_P_FOURTH = 3'h3,
    TDAF_P_TOOL   = 3'h4
  } tdaf_proto_t;

  typedef enum logic [2:0] {
    TDAF_K_SPEED = 3'h0,
    TDAF_K_FUNC  = 3'h1,
    TDAF_K_CV_WR = 3'h2,
    TDAF_K_CV_RD = 3'h3,
    TDAF_K_REG   = 3'h4
  } tdaf_kind_t;

  typedef struct packed {
    tdaf_proto_t proto;
    tdaf_kind_t  kind;
    logic        long_form;
    logic [13:0] addr;
    logic [9:0]  cv_num;
    logic [7:0]  cv_data;
  } tdaf_pkt_t;

  typedef struct packed {
    logic [7:0] short_addr;
    logic [7:0] long_hi;
    logic [7:0] long_lo;
    logic [7:0] config_bits;
    logic [7:0] proto_mask;
    logic [7:0] ext_cfg;
  } tdaf_cvset_t;

  typedef struct packed {
    logic       motor;
    logic [1:0] fgroup;
  } tdaf_hit_t;

  typedef struct packed {
    logic       ok;
    logic [2:0] slot;
  } tdaf_slot_t;

endpackage

// File: rtl/tdaf_cv_store.sv
// Storage of the six configuration variables the filter uses.
`timescale 1ns/100ps
`default_nettype none
`include "tdaf_consts.svh"
module tdaf_cv_store
  import tdaf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_slot,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  input  wire logic [2:0]  rd_slot,
  output var  logic [7:0]  rd_data_q,
  output var  tdaf_cvset_t cvset
);

  logic [7:0] mem_q [0:5];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= `TDAF_SHORT_RST;
      mem_q[1] <= `TDAF_LONG_HI_RST;
      mem_q[2] <= `TDAF_LONG_LO_RST;
      mem_q[3] <= `TDAF_CONFIG_RST;
      mem_q[4] <= `TDAF_PROTO_RST; // RL14
      mem_q[5] <= `TDAF_EXT_RST;
    end else if (wr_en) begin
      mem_q[wr_slot] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_slot];
    end
  end

  assign cvset = '{mem_q[0], mem_q[1], mem_q[2], mem_q[3], mem_q[4],
                   mem_q[5]};

endmodule
`default_nettype wire

// File: rtl/tdaf_filter.sv
// Address matching and protocol gating front end of a track decoder.
// Notes on behaviour
// RL1: Short address clear long-select: accept packets equal to short value.
// RL2: Long addresses 128 to 10239 come from the two long variables.
// RL3: Configuration bit 5 set selects long address, clear selects short.
// RL4: Exactly one of short or long address is answered at a time.
// RL5: Legacy format base address is the short address value.
// RL6: Standard and legacy packets are both acted on, no mode switch.
// RL7: Legacy format may answer up to three extra consecutive addresses.
// RL8: Motor commands only on base address; extra addresses control functions.
// RL9: Base drives group 0, base+1..+3 drive function groups 1 to 3.
// RL10: Extra address count from ext bits 7 and 3: none, one, two, three.
// RL11: Extra addresses apply only to legacy format packets.
// RL12: Auto-registering address is assigned by station, not programmable nor readable.
// RL13: Protocol mask bits 0..3 enable standard, auto, legacy, fourth format.
// RL14: Protocol mask resets to all four formats enabled.
// RL15: Writing protocol mask keeps the carrying protocol enabled.
// RL16: Programming tool access works whatever the protocol mask holds.
// RL17: Standard-only variants accept only standard packets, ignoring the mask; the code also accepts tool packets there.
// RL18: Long address compares extended packets with the assembled long value.
`timescale 1ns/100ps
`default_nettype none
`include "tdaf_consts.svh"
module tdaf_filter
  import tdaf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       dcc_only_strap,
  input  wire logic       pkt_valid,
  input  wire tdaf_pkt_t  pkt,
  output var  logic       hit_q,
  output var  tdaf_kind_t hit_kind_q,
  output var  tdaf_hit_t  hit_info_q,
  output var  logic       rd_valid_q,
  output var  logic [7:0] rd_data_q
);

  // ========================================================================
  // Reset release and strap capture
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic       strap_s1_q;
  logic       strap_s2_q;
  logic       strap_taken_q;
  logic [1:0] strap_wait_q;
  logic       dcc_only_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= dcc_only_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // The strap is taken once the synchroniser holds a settled copy. Its
  // second stage still shows the reset value for two edges after release.
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      strap_wait_q  <= 2'h0;
      strap_taken_q <= 1'b0;
      dcc_only_q    <= 1'b0;
    end else if (!strap_taken_q) begin
      if (strap_wait_q == 2'h2) begin
        strap_taken_q <= 1'b1;
        dcc_only_q    <= strap_s2_q; // RL17
      end else begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // ========================================================================
  // Helpers
  function automatic tdaf_slot_t cv_slot(input logic [9:0] num);
    tdaf_slot_t s;
    s = '{1'b1, 3'h0};
    unique case (num)
      `TDAF_CV_SHORT:   s.slot = 3'h0;
      `TDAF_CV_LONG_HI: s.slot = 3'h1;
      `TDAF_CV_LONG_LO: s.slot = 3'h2;
      `TDAF_CV_CONFIG:  s.slot = 3'h3;
      `TDAF_CV_PROTO:   s.slot = 3'h4;
      `TDAF_CV_EXT:     s.slot = 3'h5;
      default:          s.ok   = 1'b0;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] proto_bit(input tdaf_proto_t p);
    logic [7:0] b;
    b = 8'h00;
    unique case (p)
      TDAF_P_DCC:    b[`TDAF_EN_DCC_BIT]    = 1'b1;
      TDAF_P_AUTO:   b[`TDAF_EN_AUTO_BIT]   = 1'b1;
      TDAF_P_LEGACY: b[`TDAF_EN_LEG_BIT]    = 1'b1;
      TDAF_P_FOURTH: b[`TDAF_EN_FOURTH_BIT] = 1'b1;
      TDAF_P_TOOL:   b = 8'h00;
      default:       b = 8'h00;
    endcase
    return b;
  endfunction

  // ========================================================================
  // Address decision
  tdaf_cvset_t cv;
  logic [7:0]  en_mask;
  logic        long_sel;
  logic [13:0] long_addr;
  logic [13:0] short_w;
  logic [13:0] leg_off;
  logic [1:0]  n_consec;
  logic        proto_on;
  logic        dcc_hit;
  logic        leg_hit;
  logic        auto_hit;
  logic        four_hit;
  logic        addr_hit;
  logic        take;
  tdaf_hit_t   info;
  logic [13:0] auto_addr_q;
  logic        auto_ok_q;
  tdaf_slot_t  wslot;
  tdaf_slot_t  rslot;
  logic        cv_wr;
  logic        cv_rd;
  logic [7:0]  wr_val;
  logic [7:0]  store_rd;
  logic        rd_p1_q;
  logic        rd_map_q;

  assign en_mask   = dcc_only_q ? `TDAF_DCC_ONLY_MASK : cv.proto_mask; // RL17
  assign proto_on  = (pkt.proto == TDAF_P_TOOL) ||
                     ((proto_bit(pkt.proto) & en_mask) != 8'h00); // RL13 RL16
  assign long_sel  = cv.config_bits[`TDAF_LONG_SEL_BIT]; // RL3
  assign long_addr = {cv.long_hi[`TDAF_LONG_HI_BITS-1:0], cv.long_lo}; // RL18
  assign short_w   = {6'h00, cv.short_addr};
  assign leg_off   = pkt.addr - short_w; // RL5
  assign n_consec  = {cv.ext_cfg[`TDAF_CONSEC_HI_BIT],
                      cv.ext_cfg[`TDAF_CONSEC_LO_BIT]}; // RL10

  // Only one of the two standard addresses is compared at any time.
  always_comb begin
    if (long_sel) begin
      dcc_hit = pkt.long_form && (pkt.addr == long_addr); // RL2 RL4
    end else begin
      dcc_hit = !pkt.long_form && (pkt.addr == short_w) &&
                (cv.short_addr != 8'h00); // RL1 RL4
    end
  end

  // Motor commands on an extra address are dropped, not redirected.
  always_comb begin
    leg_hit = 1'b0;
    info    = '{1'b0, 2'h0};
    if (pkt.proto == TDAF_P_LEGACY && leg_off <= {12'h000, n_consec}) begin
      info.fgroup = leg_off[1:0]; // RL7 RL9 RL11
      info.motor  = (leg_off == 14'h0000) && (pkt.kind == TDAF_K_SPEED); // RL8
      leg_hit     = (leg_off == 14'h0000) || (pkt.kind != TDAF_K_SPEED); // RL8
    end else if (pkt.kind == TDAF_K_SPEED) begin
      info.motor = 1'b1;
    end
  end

  assign auto_hit = auto_ok_q && (pkt.addr == auto_addr_q);
  assign four_hit = !pkt.long_form && (pkt.addr == short_w);

  always_comb begin
    unique case (pkt.proto)
      TDAF_P_DCC:    addr_hit = dcc_hit;
      TDAF_P_LEGACY: addr_hit = leg_hit; // RL6
      TDAF_P_AUTO:   addr_hit = auto_hit;
      TDAF_P_FOURTH: addr_hit = four_hit;
      TDAF_P_TOOL:   addr_hit = 1'b1; // RL16
      default:       addr_hit = 1'b0;
    endcase
  end

  assign take = pkt_valid && proto_on && addr_hit &&
                (pkt.kind != TDAF_K_REG);

  // ========================================================================
  // Automatic address assignment
  // The assigned address lives outside the variable store, so no
  // configuration read or write can reach it.
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      auto_addr_q <= 14'h0000;
      auto_ok_q   <= 1'b0;
    end else if (pkt_valid && proto_on && pkt.proto == TDAF_P_AUTO &&
                 pkt.kind == TDAF_K_REG) begin
      auto_addr_q <= pkt.addr; // RL12
      auto_ok_q   <= 1'b1;
    end
  end

  // ========================================================================
  // Configuration access
  assign wslot  = cv_slot(pkt.cv_num);
  assign rslot  = cv_slot(pkt.cv_num);
  assign cv_wr  = take && pkt.kind == TDAF_K_CV_WR && wslot.ok;
  assign cv_rd  = take && pkt.kind == TDAF_K_CV_RD;
  assign wr_val = (pkt.cv_num == `TDAF_CV_PROTO) ?
                  (pkt.cv_data | proto_bit(pkt.proto)) : pkt.cv_data; // RL15

  tdaf_cv_store u_store (
    .clock     (clock),
    .rst_n     (rst_s2_q),
    .wr_en     (cv_wr),
    .wr_slot   (wslot.slot),
    .wr_data   (wr_val),
    .rd_en     (cv_rd && rslot.ok),
    .rd_slot   (rslot.slot),
    .rd_data_q (store_rd),
    .cvset     (cv)
  );

  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rd_p1_q    <= 1'b0;
      rd_map_q   <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_p1_q    <= cv_rd;
      rd_map_q   <= rslot.ok;
      rd_valid_q <= rd_p1_q;
      rd_data_q  <= (rd_p1_q && rd_map_q) ? store_rd : 8'h00;
    end
  end

  // ========================================================================
  // Accepted packet outputs
  always_ff @(posedge clock or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      hit_q      <= 1'b0;
      hit_kind_q <= TDAF_K_SPEED;
      hit_info_q <= '{1'b0, 2'h0};
    end else begin
      hit_q      <= take;
      hit_kind_q <= pkt.kind;
      hit_info_q <= info;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s2_q);

  short_addr_hit_a: assert property ( // RL1
    pkt_valid && pkt.proto == TDAF_P_DCC && !long_sel && !pkt.long_form &&
    en_mask[0] && pkt.addr == short_w && cv.short_addr != 8'h00 &&
    pkt.kind != TDAF_K_REG |=> hit_q)
    else $error("short address packet not accepted");

  long_addr_hit_a: assert property ( // RL2
    pkt_valid && pkt.proto == TDAF_P_DCC && long_sel && pkt.long_form &&
    en_mask[0] && pkt.addr == long_addr && pkt.kind != TDAF_K_REG
    |=> hit_q)
    else $error("long address packet not accepted");

  one_address_a: assert property ( // RL4
    hit_q && $past(pkt.proto) == TDAF_P_DCC |->
    $past(pkt.long_form) == $past(long_sel))
    else $error("wrong standard address form accepted");

  motor_base_a: assert property ( // RL8
    hit_q && hit_info_q.motor |-> hit_info_q.fgroup == 2'h0)
    else $error("motor command on extra address");

  consec_legacy_a: assert property ( // RL11
    hit_q && hit_info_q.fgroup != 2'h0 |->
    $past(pkt.proto) == TDAF_P_LEGACY &&
    $past(leg_off) <= {12'h000, $past(n_consec)})
    else $error("extra address used outside legacy range");

  proto_gate_a: assert property ( // RL13
    pkt_valid && pkt.proto != TDAF_P_TOOL &&
    (proto_bit(pkt.proto) & en_mask) == 8'h00 |=> !hit_q)
    else $error("disabled format accepted");

  mask_keep_a: assert property ( // RL15
    cv_wr && pkt.cv_num == `TDAF_CV_PROTO && pkt.proto != TDAF_P_TOOL
    |=> (cv.proto_mask & $past(proto_bit(pkt.proto))) != 8'h00)
    else $error("carrier format disabled by its own write");

  tool_access_a: assert property ( // RL16
    pkt_valid && pkt.proto == TDAF_P_TOOL && pkt.kind != TDAF_K_REG
    |=> hit_q)
    else $error("tool access refused");

  dcc_only_a: assert property ( // RL17
    pkt_valid && dcc_only_q && pkt.proto != TDAF_P_DCC &&
    pkt.proto != TDAF_P_TOOL |=> !hit_q)
    else $error("other format accepted on standard-only variant");

  read_answer_a: assert property (
    cv_rd && !$past(cv_rd) |=> !rd_valid_q ##1 rd_valid_q)
    else $error("read answer not two cycles later");

  legacy_cover_c: cover property (hit_q && hit_info_q.fgroup == 2'h3);
  long_cover_c: cover property (hit_q && $past(long_sel));
  mask_cover_c: cover property (cv_wr && pkt.cv_num == `TDAF_CV_PROTO);
  read_cover_c: cover property (rd_valid_q && rd_data_q != 8'h00);

endmodule
`default_nettype wire

// File: tb/tdaf_station.sv
// Behavioural command station that puts packets on the filter's port.
`timescale 1ns/100ps
`default_nettype none
module tdaf_station
  import tdaf_pkg::*;
(
  input  wire logic      clock,
  output var  logic      pkt_valid,
  output var  tdaf_pkt_t pkt
);
  initial begin
    pkt_valid = 1'b0;
    pkt       = '0;
  end

  // ==========================================================================
  // Packet delivery
  // Once released the fields are inverted, so the filter cannot lean on a
  // stale packet the way it could if the last value simply lingered.
  task automatic send(input tdaf_pkt_t p);
    @(posedge clock);
    pkt_valid <= 1'b1;
    pkt       <= p;
    @(posedge clock);
    pkt_valid <= 1'b0;
    pkt       <= ~p;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the track decoder address filter.
`timescale 1ns/100ps
`default_nettype none
`include "tdaf_consts.svh"
module tb_top
  import tdaf_pkg::*;
;
  localparam logic [9:0] CVN [7] = '{`TDAF_CV_SHORT, `TDAF_CV_LONG_HI,
    `TDAF_CV_LONG_LO, `TDAF_CV_CONFIG, `TDAF_CV_PROTO, `TDAF_CV_EXT, 10'h040};
  localparam logic [9:0] RCV [4] = '{`TDAF_CV_CONFIG, `TDAF_CV_PROTO,
    `TDAF_CV_EXT, 10'h040};
  localparam logic [7:0] ECFG [4] = '{8'h13, 8'h1b, 8'h93, 8'h9b};

  logic        clock;
  logic        rst_n;
  logic        strap;
  logic        pkt_valid;
  tdaf_pkt_t   pkt;
  logic        hit_q;
  tdaf_kind_t  hit_kind_q;
  tdaf_hit_t   hit_info_q;
  logic        rd_valid_q;
  logic [7:0]  rd_data_q;
  int          bad_count;
  int          comparisons;
  int          cycles;
  int          seed;
  logic [7:0]  cv_short, hi, lo, cfg, mask, ext;
  logic        reg_ok, strap_m, lf;
  logic [13:0] reg_addr, a;
  logic [31:0] r;
  tdaf_proto_t pr;

  tdaf_filter uut (
    .clock          (clock),
    .rst_n          (rst_n),
    .dcc_only_strap (strap),
    .pkt_valid      (pkt_valid),
    .pkt            (pkt),
    .hit_q          (hit_q),
    .hit_kind_q     (hit_kind_q),
    .hit_info_q     (hit_info_q),
    .rd_valid_q     (rd_valid_q),
    .rd_data_q      (rd_data_q)
  );

  tdaf_station u_st (
    .clock     (clock),
    .pkt_valid (pkt_valid),
    .pkt       (pkt)
  );

  always #4 clock = ~clock;

  // ==========================================================================
  // Reporting
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Reference model of the variables and the matching
  function automatic tdaf_pkt_t mk(tdaf_proto_t p, tdaf_kind_t k,
      logic l, logic [13:0] ad, logic [9:0] n, logic [7:0] d);
    return '{p, k, l, ad, n, d};
  endfunction

  function automatic logic proto_on(tdaf_pkt_t p);
    if (p.proto == TDAF_P_TOOL) return 1'b1;
    if (strap_m) return p.proto == TDAF_P_DCC;
    return mask[p.proto[1:0]];
  endfunction

  function automatic logic [3:0] predict(tdaf_pkt_t p);
    logic [13:0] off;
    logic        ok;
    off = p.addr - {6'h00, cv_short};
    case (p.proto)
      TDAF_P_DCC:    ok = cfg[5] ? p.long_form && p.addr == {hi[5:0], lo}
                        : !p.long_form && p.addr == {6'h00, cv_short}
                          && cv_short != 8'h00;
      TDAF_P_AUTO:   ok = reg_ok && p.addr == reg_addr;
      TDAF_P_LEGACY: ok = off <= {12'h000, ext[7], ext[3]}
                        && (p.kind != TDAF_K_SPEED || off == 14'h0000);
      TDAF_P_FOURTH: ok = !p.long_form && p.addr == {6'h00, cv_short};
      default:       ok = 1'b1;
    endcase
    ok = ok && proto_on(p) && p.kind != TDAF_K_REG;
    return {ok, p.kind == TDAF_K_SPEED,
            p.proto == TDAF_P_LEGACY ? off[1:0] : 2'h0};
  endfunction

  function automatic logic [7:0] cv_rd(logic [9:0] n);
    case (n)
      `TDAF_CV_SHORT:   return cv_short;
      `TDAF_CV_LONG_HI: return hi;
      `TDAF_CV_LONG_LO: return lo;
      `TDAF_CV_CONFIG:  return cfg;
      `TDAF_CV_PROTO:   return mask;
      `TDAF_CV_EXT:     return ext;
      default:          return 8'h00;
    endcase
  endfunction

  task automatic cv_wr(tdaf_pkt_t p);
    case (p.cv_num)
      `TDAF_CV_SHORT:   cv_short = p.cv_data;
      `TDAF_CV_LONG_HI: hi = p.cv_data;
      `TDAF_CV_LONG_LO: lo = p.cv_data;
      `TDAF_CV_CONFIG:  cfg = p.cv_data;
      `TDAF_CV_PROTO:   mask = p.cv_data | (p.proto == TDAF_P_TOOL ? 8'h00
                          : 8'h01 << p.proto[1:0]);
      `TDAF_CV_EXT:     ext = p.cv_data;
      default:          ;
    endcase
  endtask

  // One packet, then the accept pulse and any read answer are compared.
  task automatic xfer(input tdaf_pkt_t p);
    logic [3:0] e;
    logic [7:0] rv;
    e  = predict(p);
    rv = cv_rd(p.cv_num);
    if (p.kind == TDAF_K_REG && p.proto == TDAF_P_AUTO && proto_on(p)) begin
      reg_ok   = 1'b1;
      reg_addr = p.addr;
    end
    u_st.send(p);
    #1;
    check({7'h00, hit_q}, {7'h00, e[3]});
    if (e[3]) begin
      check({5'h00, hit_kind_q}, {5'h00, p.kind});
      check({5'h00, hit_info_q}, {5'h00, e[2:0]});
      if (p.kind == TDAF_K_CV_WR) cv_wr(p);
    end
    @(posedge clock);
    #1;
    check({7'h00, rd_valid_q}, {7'h00, e[3] && p.kind == TDAF_K_CV_RD});
    if (e[3] && p.kind == TDAF_K_CV_RD) check(rd_data_q, rv);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clock);
    rst_n <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    cv_short = `TDAF_SHORT_RST;
    hi       = `TDAF_LONG_HI_RST;
    lo       = `TDAF_LONG_LO_RST;
    cfg      = `TDAF_CONFIG_RST;
    mask     = 8'h0f;
    ext      = 8'h13;
    reg_ok   = 1'b0;
    strap_m  = s;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    strap = 1'b0;
    seed = 78;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    do_reset(1'b0);
    foreach (CVN[i]) xfer(mk(TDAF_P_DCC, TDAF_K_CV_RD, 0, 3, CVN[i], 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 0, 14'h0004, 0, 0));
    xfer(mk(TDAF_P_LEGACY, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 0, 3, `TDAF_CV_LONG_HI, 8'hc3));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 0, 3, `TDAF_CV_LONG_LO, 8'he8));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 0, 3, `TDAF_CV_CONFIG, 8'h20));
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 1, 14'h03e8, 0, 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 1, 14'h03e8, `TDAF_CV_LONG_HI, 8'he7));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 1, 14'h03e8, `TDAF_CV_LONG_LO, 8'hff));
    xfer(mk(TDAF_P_DCC, TDAF_K_FUNC, 1, 14'h27ff, 0, 0));
    xfer(mk(TDAF_P_LEGACY, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 1, 14'h27ff, `TDAF_CV_CONFIG, 0));
    foreach (ECFG[i]) begin
      xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 0, 3, `TDAF_CV_EXT, ECFG[i]));
      for (int j = 0; j < 5; j++) begin
        xfer(mk(TDAF_P_LEGACY, TDAF_K_FUNC, 0, 14'(3 + j), 0, 0));
        xfer(mk(TDAF_P_LEGACY, TDAF_K_SPEED, 0, 14'(3 + j), 0, 0));
      end
      xfer(mk(TDAF_P_DCC, TDAF_K_FUNC, 0, 14'h0004, 0, 0));
    end
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO, 8'h00));
    xfer(mk(TDAF_P_DCC, TDAF_K_CV_RD, 0, 3, `TDAF_CV_PROTO, 0));
    xfer(mk(TDAF_P_LEGACY, TDAF_K_FUNC, 0, 14'h0003, 0, 0));
    for (int b = 0; b < 4; b++) begin
      xfer(mk(TDAF_P_TOOL, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO,
              8'h01 << b));
      for (int q = 0; q < 4; q++) begin
        xfer(mk(tdaf_proto_t'(q), TDAF_K_REG, 0, 14'h0055, 0, 0));
        xfer(mk(tdaf_proto_t'(q), TDAF_K_SPEED, 0,
                q == 1 ? 14'h0055 : 14'h0003, 0, 0));
      end
    end
    xfer(mk(TDAF_P_TOOL, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO, 8'h0f));
    xfer(mk(TDAF_P_LEGACY, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO, 0));
    xfer(mk(TDAF_P_TOOL, TDAF_K_CV_RD, 0, 3, `TDAF_CV_PROTO, 0));
    xfer(mk(TDAF_P_TOOL, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO, 8'h0f));
    repeat (300) begin
      r  = $random(seed);
      pr = tdaf_proto_t'(r[1:0]);
      lf = (pr == TDAF_P_DCC) && r[7];
      a  = lf ? {hi[5:0], lo} : (r[8] ? 14'({6'h00, cv_short} + r[6:5])
                                      : r[22:9]);
      xfer(mk(pr, tdaf_kind_t'(r[4:2] > 3'h4 ? 3'h1 : r[4:2]), lf, a,
              RCV[r[24:23]], r[31:24]));
    end
    do_reset(1'b1);
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_LEGACY, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_TOOL, TDAF_K_CV_WR, 0, 3, `TDAF_CV_PROTO, 8'h04));
    xfer(mk(TDAF_P_DCC, TDAF_K_SPEED, 0, 14'h0003, 0, 0));
    xfer(mk(TDAF_P_FOURTH, TDAF_K_FUNC, 0, 14'h0003, 0, 0));
    give_verdict();
  end
endmodule
`default_nettype wire
